// *** design/dtb_pkg.sv ***
// Shared constants and carrier types for the two-word burst memory port
package dtb_pkg;

  // Burst address width of the narrow organisation (4M x 18)
  localparam int DTB_ADDR_W = 21;
  // Word width of the narrow organisation
  localparam int DTB_WORD_W = 18;
  // Word width of the wide organisation
  localparam int DTB_WIDE_WORD_W = 36;
  // Words per burst
  localparam int DTB_BURST_LEN = 2;
  // Index of the first and second word of a burst
  localparam logic DTB_WORD0 = 1'b0;
  localparam logic DTB_WORD1 = 1'b1;
  // Read latency in half cycles with the loop bypassed and enabled
  localparam int DTB_LAT_HALF_LONG = 5;
  localparam int DTB_LAT_HALF_SHORT = 2;
  // Synchroniser depth for pin inputs from another domain
  localparam int DTB_SYNC_STAGES = 2;
  // Polarity of the active-low load strobe when a request is present
  localparam logic DTB_LOAD_ACTIVE = 1'b0;
  // Read and write encodings of the direction pin
  localparam logic DTB_DIR_READ = 1'b1;
  localparam logic DTB_DIR_WRITE = 1'b0;

  // Pipeline stage flags that travel with an address
  typedef struct packed {
    logic valid;
    logic is_read;
  } dtb_stage_t;

  // Idle value of a stage
  localparam dtb_stage_t DTB_STAGE_IDLE = '{valid: 1'b0, is_read: 1'b0};

endpackage : dtb_pkg

// *** design/dtb_sync.sv ***
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module dtb_sync
  import dtb_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta_r;

  // Two-stage capture of the foreign level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : dtb_sync

// *** design/dtb_core.sv ***
// Memory core holding two words per burst address
`timescale 1ns/1ps
module dtb_core
  import dtb_pkg::*;
#(
  parameter int ADDR_W = DTB_ADDR_W,
  parameter int WORD_W = DTB_WORD_W
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [WORD_W-1:0] wr_word0,
  input wire logic [WORD_W-1:0] wr_word1,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [WORD_W-1:0] rd_word0,
  output logic [WORD_W-1:0] rd_word1
);

  // Storage, two consecutive words per address
  logic [WORD_W-1:0] mem [0:(2**(ADDR_W+1))-1];

  // Self-timed commit of both words of a burst
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[{wr_addr, DTB_WORD0}] <= wr_word0;
      mem[{wr_addr, DTB_WORD1}] <= wr_word1;
    end
  end

  // Asynchronous read of both words
  assign rd_word0 = mem[{rd_addr, DTB_WORD0}];
  assign rd_word1 = mem[{rd_addr, DTB_WORD1}];

endmodule : dtb_core

// *** design/dtb_port.sv ***
// Double-data-rate two-word burst port of a pipelined memory
// Function
// [RULE1] Address captured once per cycle, true rise
// [RULE2] Write words taken on true, complement rises
// [RULE3] Read words driven on both strobe rises
// [RULE4] Address holds two sequential words, 18/36 bits
// [RULE5] Bypass pin high: read data after 2.5
// [RULE6] Bypass pin low: read data after 1
// [RULE7] Valid flag marks valid read words
// [RULE8] Free-running echo strobes track read data
// [RULE9] All synchronous inputs registered on strobes
// [RULE10] Read data launched from output registers
// [RULE11] Shared data pins, device drives reads only
// [RULE12] Writes complete internally, self-timed
// [RULE13] Controller turns bus around, no overlap
`timescale 1ns/1ps
module dtb_port
  import dtb_pkg::*;
#(
  parameter int ADDR_W = DTB_ADDR_W,
  parameter int WORD_W = DTB_WORD_W
) (
  // Core-side clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Main input strobe and its complement
  input wire logic k_clk,
  input wire logic k_clk_n,
  // Load strobe, active low
  input wire logic load_n,
  // Direction, high for read
  input wire logic read_not_write,
  // Burst address
  input wire logic [ADDR_W-1:0] addr,
  // Shared data pins: input, output, output enable (low drives)
  input wire logic [WORD_W-1:0] dq_in,
  output logic [WORD_W-1:0] dq_out,
  output logic dq_oe_n,
  // Echo strobes and read valid flag
  output logic echo_strobe,
  output logic echo_strobe_n,
  output logic valid_flag,
  // Latency select pin, high for the long latency
  input wire logic pll_bypass_pin,
  // Core-side status
  output logic write_done,
  output logic long_latency
);

  // Half-cycle phase toggles, one per strobe
  logic pos_tog_r;
  logic neg_tog_r;
  // High during the half cycle that follows a true rise
  logic half_true;
  // Latency select in the strobe domain
  logic byp_k;
  // Read pipeline: capture, core read, long-latency hold
  dtb_stage_t rd1_r;
  logic [ADDR_W-1:0] rd1_addr_r;
  logic rd2_v_r;
  logic [WORD_W-1:0] rd2_w0_r;
  logic [WORD_W-1:0] rd2_w1_r;
  logic rd3_v_r;
  logic [WORD_W-1:0] rd3_w0_r;
  logic [WORD_W-1:0] rd3_w1_r;
  // Core read words
  logic [WORD_W-1:0] core_w0;
  logic [WORD_W-1:0] core_w1;
  // Write pipeline: capture, first word, commit
  dtb_stage_t wr1_r;
  logic [ADDR_W-1:0] wr1_addr_r;
  logic wr2_v_r;
  logic [ADDR_W-1:0] wr2_addr_r;
  logic [WORD_W-1:0] wd0_r;
  logic [WORD_W-1:0] wd1_r;
  // Commit toggle handed to the core side
  logic done_tog_r;
  // Output registers, one per strobe edge
  logic [WORD_W-1:0] out_t_r;
  logic out_t_v_r;
  logic [WORD_W-1:0] out_c_r;
  logic out_c_v_r;
  // Core-side synchronised signals
  logic done_tog_s;
  logic done_tog_d_r;
  logic byp_s;
  logic write_done_r;
  logic long_latency_r;

  // Request of the given direction present at the pins
  function automatic logic req_of(
    input logic ld_n,
    input logic rnw,
    input logic dir
  );
    // Load strobe active and direction matching
    return (ld_n == DTB_LOAD_ACTIVE) && (rnw == dir);
  endfunction : req_of

  // Latency select pin into the strobe domain
  dtb_sync #(
    .WIDTH(1)
  ) u_byp_k (
    .clk(k_clk),
    .rst_n(rst_n),
    .async_in(pll_bypass_pin),
    .sync_out(byp_k)
  );

  // Memory core, written on the true strobe
  dtb_core #(
    .ADDR_W(ADDR_W),
    .WORD_W(WORD_W)
  ) u_core (
    .clk(k_clk),
    .wr_en(wr2_v_r),
    .wr_addr(wr2_addr_r),
    .wr_word0(wd0_r),
    .wr_word1(wd1_r),
    .rd_addr(rd1_addr_r),
    .rd_word0(core_w0),
    .rd_word1(core_w1)
  );

  // Phase toggle on each true rise
  always_ff @(posedge k_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_tog_r <= 1'b0;
    end else begin
      pos_tog_r <= ~pos_tog_r;
    end
  end

  // Phase copy on each complement rise
  // Following the true toggle keeps the echo in phase whichever half reset ends in
  always_ff @(posedge k_clk_n or negedge rst_n) begin
    if (!rst_n) begin
      neg_tog_r <= 1'b0;
    end else begin
      neg_tog_r <= pos_tog_r;
    end
  end

  // Toggles differ only between a true rise and the next complement rise
  assign half_true = pos_tog_r ^ neg_tog_r;

  // Request capture, true rise only, one address per burst
  always_ff @(posedge k_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd1_r <= DTB_STAGE_IDLE;
      wr1_r <= DTB_STAGE_IDLE;
      rd1_addr_r <= '0;
      wr1_addr_r <= '0;
    end else begin
      // Load, direction and address registered at the pins [RULE9] [RULE1]
      rd1_r.valid <= req_of(load_n, read_not_write, DTB_DIR_READ);
      rd1_r.is_read <= (read_not_write == DTB_DIR_READ);
      wr1_r.valid <= req_of(load_n, read_not_write, DTB_DIR_WRITE);
      wr1_r.is_read <= 1'b0;
      // Addresses held only when a request is present
      if (req_of(load_n, read_not_write, DTB_DIR_READ)) begin
        rd1_addr_r <= addr; // [RULE1]
      end
      if (req_of(load_n, read_not_write, DTB_DIR_WRITE)) begin
        wr1_addr_r <= addr; // [RULE1]
      end
    end
  end

  // Read pipeline stages on the true strobe
  always_ff @(posedge k_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd2_v_r <= 1'b0;
      rd2_w0_r <= '0;
      rd2_w1_r <= '0;
      rd3_v_r <= 1'b0;
      rd3_w0_r <= '0;
      rd3_w1_r <= '0;
    end else begin
      // Both words of the addressed pair read together [RULE4]
      rd2_v_r <= rd1_r.valid;
      rd2_w0_r <= core_w0;
      rd2_w1_r <= core_w1;
      // Extra hold stage for the long latency
      rd3_v_r <= rd2_v_r;
      rd3_w0_r <= rd2_w0_r;
      rd3_w1_r <= rd2_w1_r;
    end
  end

  // Write pipeline, first word on the true strobe
  always_ff @(posedge k_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr2_v_r <= 1'b0;
      wr2_addr_r <= '0;
      wd0_r <= '0;
    end else begin
      wr2_v_r <= wr1_r.valid;
      wr2_addr_r <= wr1_addr_r;
      // First write word on the true rise after capture [RULE2] [RULE9]
      if (wr1_r.valid) begin
        wd0_r <= dq_in;
      end
    end
  end

  // Second write word on the complement strobe
  always_ff @(posedge k_clk_n or negedge rst_n) begin
    if (!rst_n) begin
      wd1_r <= '0;
    end else if (wr2_v_r) begin
      // Taken half a cycle after the first word [RULE2] [RULE9]
      wd1_r <= dq_in;
    end
  end

  // Commit toggle; the core write itself is self-timed by wr2_v_r
  always_ff @(posedge k_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_tog_r <= 1'b0;
    end else if (wr2_v_r) begin
      // No action from the controller beyond the data [RULE12]
      done_tog_r <= ~done_tog_r;
    end
  end

  // True-strobe output register
  always_ff @(posedge k_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_t_r <= '0;
      out_t_v_r <= 1'b0;
    end else if (byp_k) begin
      // Long latency: second word three cycles after capture [RULE5] [RULE10]
      out_t_r <= rd3_w1_r;
      out_t_v_r <= rd3_v_r;
    end else begin
      // Short latency: first word one cycle after capture [RULE6] [RULE10]
      out_t_r <= core_w0;
      out_t_v_r <= rd1_r.valid;
    end
  end

  // Complement-strobe output register
  always_ff @(posedge k_clk_n or negedge rst_n) begin
    if (!rst_n) begin
      out_c_r <= '0;
      out_c_v_r <= 1'b0;
    end else if (byp_k) begin
      // Long latency: first word 2.5 cycles after capture [RULE5] [RULE10]
      out_c_r <= rd3_w0_r;
      out_c_v_r <= rd3_v_r;
    end else begin
      // Short latency: second word 1.5 cycles after capture [RULE6] [RULE10]
      out_c_r <= rd2_w1_r;
      out_c_v_r <= rd2_v_r;
    end
  end

  // Edge mux: each register owns the half cycle after its strobe [RULE3] [RULE4]
  assign dq_out = half_true ? out_t_r : out_c_r;
  // Pins driven only while read words stand [RULE11]
  assign dq_oe_n = ~(half_true ? out_t_v_r : out_c_v_r);
  // Valid flag follows the word on the pins [RULE7]
  assign valid_flag = half_true ? out_t_v_r : out_c_v_r;
  // Echo strobes run free with the same phase as the data [RULE8]
  assign echo_strobe = half_true;
  assign echo_strobe_n = ~half_true;

  // Commit toggle into the core domain
  dtb_sync #(
    .WIDTH(1)
  ) u_done_s (
    .clk(sys_clk),
    .rst_n(rst_n),
    .async_in(done_tog_r),
    .sync_out(done_tog_s)
  );

  // Latency select pin into the core domain
  dtb_sync #(
    .WIDTH(1)
  ) u_byp_s (
    .clk(sys_clk),
    .rst_n(rst_n),
    .async_in(pll_bypass_pin),
    .sync_out(byp_s)
  );

  // Core-side status: one pulse per committed burst, latency level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_tog_d_r <= 1'b0;
      write_done_r <= 1'b0;
      long_latency_r <= 1'b0;
    end else begin
      done_tog_d_r <= done_tog_s;
      write_done_r <= done_tog_s ^ done_tog_d_r;
      long_latency_r <= byp_s;
    end
  end

  // Core-side outputs from their registers
  assign write_done = write_done_r;
  assign long_latency = long_latency_r;

endmodule : dtb_port

// *** testbench/dtb_port_checker.sv ***
// Concurrent checks on the pins of the burst memory port
`timescale 1ns/1ps
module dtb_port_checker
  import dtb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic k_clk,
  input wire logic k_clk_n,
  input wire logic load_n,
  input wire logic read_not_write,
  input wire logic dq_oe_n,
  input wire logic echo_strobe,
  input wire logic echo_strobe_n,
  input wire logic valid_flag,
  input wire logic pll_bypass_pin,
  input wire logic write_done
);
  // Read and write requests as seen on a true strobe rise
  sequence rd_s;
    !load_n && read_not_write;
  endsequence
  sequence wr_s;
    !load_n && !read_not_write;
  endsequence
  // Word0 sampled at the true rise three cycles on
  AST_LONG_LAT: assert property (@(posedge k_clk) disable iff (!rst_n)
    rd_s ##0 pll_bypass_pin |-> ##3 (valid_flag && !dq_oe_n)) else $error("late long read");
  // Word1 sampled two cycles on
  AST_SHORT_LAT: assert property (@(posedge k_clk) disable iff (!rst_n)
    rd_s ##0 !pll_bypass_pin |-> ##2 valid_flag) else $error("late short read");
  // No valid word in long latency without a read three cycles before
  AST_VALID_CAUSE: assert property (@(posedge k_clk) disable iff (!rst_n)
    valid_flag && pll_bypass_pin |-> $past(!load_n && read_not_write, 3))
    else $error("valid flag without read");
  // Bus not driven in the half cycle after a write's second word
  AST_WR_NO_DRIVE: assert property (@(posedge k_clk) disable iff (!rst_n)
    wr_s |-> ##2 dq_oe_n) else $error("device drove during write");
  AST_VALID_OE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    valid_flag == !dq_oe_n) else $error("valid flag and enable differ");
  AST_ECHO_PAIR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    echo_strobe != echo_strobe_n) else $error("echo pair not inverse");
  // Echo high through the true half, low through the complement half
  AST_ECHO_HIGH: assert property (@(posedge k_clk_n) disable iff (!rst_n)
    $past(rst_n) |-> echo_strobe) else $error("echo low in true half");
  AST_ECHO_LOW: assert property (@(posedge k_clk) disable iff (!rst_n)
    $past(rst_n) |-> !echo_strobe) else $error("echo high in complement half");
  AST_WD_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    write_done |=> !write_done) else $error("write done held");
endmodule : dtb_port_checker

// *** testbench/dtb_ctl_model.sv ***
// Model of the memory controller on the link side
`timescale 1ns/1ps
module dtb_ctl_model
  import dtb_pkg::*;
(
  output logic k_clk,
  output logic k_clk_n,
  output logic load_n,
  output logic read_not_write,
  output logic [5:0] addr,
  output logic [17:0] ctl_dq
);
  // Free-running strobe pair, phase unrelated to the core clock
  assign k_clk_n = ~k_clk;
  initial begin
    k_clk = 1'b0;
    load_n = 1'b1;
    read_not_write = 1'b1;
    addr = 6'h00;
    ctl_dq = 18'h00000;
    #7;
    forever #62.5 k_clk = ~k_clk;
  end
  // One burst; signals move a quarter cycle after a strobe rise
  task automatic xfer(input logic rnw, input logic [5:0] a, input logic [17:0] w0,
    input logic [17:0] w1);
    @(posedge k_clk);
    #30 load_n = 1'b0;
    read_not_write = rnw;
    addr = a;
    // Request taken here; word0 must stand for the next true rise
    @(posedge k_clk);
    #30 load_n = 1'b1;
    addr = ~a;
    if (!rnw) ctl_dq = w0;
    // Word0 taken here; word1 must stand for the next complement rise
    @(posedge k_clk);
    #30 if (!rnw) ctl_dq = w1;
    @(posedge k_clk_n);
    #30 ctl_dq = ~ctl_dq;
  endtask : xfer
endmodule : dtb_ctl_model

// *** testbench/tb.sv ***
// Testbench for the burst memory port
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module tb;
  import dtb_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic pll_bypass_pin = 1'b1;
  logic k_clk, k_clk_n, load_n, read_not_write;
  logic [5:0] addr;
  logic [17:0] ctl_dq, dq_in, dq_out;
  logic dq_oe_n, echo_strobe, echo_strobe_n, valid_flag, write_done, long_latency;
  int err_count = 0;
  int checks = 0;
  int wd_cnt = 0;
  // Rows: address, word0, word1
  logic [41:0] rows [4] = '{{6'h00, 18'h00001, 18'h3fffe}, {6'h3f, 18'h2aaaa, 18'h15555},
    {6'h15, 18'h12345, 18'h0abcd}, {6'h2a, 18'h3ffff, 18'h00000}};
  always #12.5 sys_clk = ~sys_clk;
  // Shared pins resolve to whichever side drives
  assign dq_in = (dq_oe_n === 1'b0) ? dq_out : ctl_dq;
  always @(posedge sys_clk) if (write_done === 1'b1) wd_cnt++;
  dtb_ctl_model ctl (.k_clk, .k_clk_n, .load_n, .read_not_write, .addr, .ctl_dq);
  dtb_port #(.ADDR_W(6), .WORD_W(18)) dut (.sys_clk, .rst_n, .k_clk, .k_clk_n, .load_n,
    .read_not_write, .addr, .dq_in, .dq_out, .dq_oe_n, .echo_strobe, .echo_strobe_n,
    .valid_flag, .pll_bypass_pin, .write_done, .long_latency);
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  // Read a burst and watch both words at their half cycles
  task automatic rd(input logic [41:0] r);
    fork
      ctl.xfer(1'b1, r[41:36], 18'h00000, 18'h00000);
      begin
        // Request edge, capture edge, then one cycle on
        repeat (3) @(posedge k_clk);
        if (pll_bypass_pin) begin
          @(posedge k_clk);
          @(posedge k_clk_n);
        end
        #30 `CHK({valid_flag, dq_oe_n, echo_strobe, dq_out}, {2'b10, !pll_bypass_pin, r[35:18]})
        if (pll_bypass_pin) @(posedge k_clk); else @(posedge k_clk_n);
        #30 `CHK({valid_flag, echo_strobe, dq_out}, {1'b1, pll_bypass_pin, r[17:0]})
        if (pll_bypass_pin) @(posedge k_clk_n); else @(posedge k_clk);
        #30 `CHK({valid_flag, dq_oe_n}, 2'b01)
      end
    join
  endtask : rd
  task automatic do_reset(input logic pin);
    @(negedge sys_clk) rst_n = 1'b0;
    pll_bypass_pin = pin;
    repeat (5) @(posedge k_clk);
    `CHK({dq_oe_n, valid_flag, echo_strobe, write_done, long_latency}, 5'h10)
    @(negedge sys_clk) rst_n = 1'b1;
    repeat (3) @(posedge k_clk);
  endtask : do_reset
  initial begin
    do_reset(1'b1);
    // Each write is read back one cycle after the first edge that may see it
    foreach (rows[i]) begin
      ctl.xfer(1'b0, rows[i][41:36], rows[i][35:18], rows[i][17:0]);
      rd(rows[i]);
      $display("row %0d done", i);
    end
    `CHK(long_latency, 1'b1)
    `CHK(wd_cnt, 4)
    // Short latency after a second reset; memory keeps its words
    do_reset(1'b0);
    rd(rows[1]);
    `CHK(long_latency, 1'b0)
    $display("short latency done");
    conclude();
  end
  initial begin
    #400000;
    err_count++;
    conclude();
  end
endmodule : tb
bind dtb_port dtb_port_checker chk (.sys_clk, .rst_n, .k_clk, .k_clk_n, .load_n,
  .read_not_write, .dq_oe_n, .echo_strobe, .echo_strobe_n, .valid_flag, .pll_bypass_pin,
  .write_done);
